// [core/flash_status_flag_readback.sv]
// Status flag substitution for flash program/erase read-back
`timescale 1ns/100ps
`include "flash_status_consts.svh"

module flash_status_flag_readback #(
    parameter int TIMEOUT_CYCLES = `FLS_TIMEOUT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire flash_status_pkg::cpu_rd_t bus_in,
    input wire logic [7:0] array_data_in,
    input wire flash_status_pkg::seq_cmd_t cmd_in,
    output logic [7:0] rd_data_out,
    output logic busy_out,
    output logic timeout_out,
    output logic cmd_ignored_out
);
    import flash_status_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] sector_of(input logic [15:0] a);
        sector_of = a[`FLS_SECT_MSB:`FLS_SECT_LSB];
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_t state_q, state_d;
    logic [`FLS_NUM_SECT-1:0] sect_q, sect_d;
    logic bank_q;
    logic last_bit7_q;
    logic lock_q;
    logic chip_q;
    logic tmo_q, tmo_d;
    logic [31:0] tmo_cnt_q, tmo_cnt_d;
    logic toggle_q;
    logic [7:0] rd_data_q, rd_data_d;

    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    wire is_read = (state_q == ST_READ);
    wire is_prog = (state_q == ST_PROG);
    wire is_ewait = (state_q == ST_EWAIT);
    wire is_erase = (state_q == ST_ERASE);
    wire is_susp = (state_q == ST_SUSP);
    wire running = is_prog | is_erase;
    wire cmd_locked = running & ~tmo_q;
    wire take_reset = cmd_in.reset_cmd & ~cmd_locked;
    wire take_prog = cmd_in.prog_start & is_read;
    wire take_chip = cmd_in.chip_start & is_read;
    wire take_sect = cmd_in.sector_start & (is_read | is_ewait);
    wire take_susp = cmd_in.suspend & is_erase & ~chip_q;
    wire take_resume = cmd_in.resume & is_susp;
    wire done = cmd_in.algo_done & running & ~lock_q;
    wire any_cmd = cmd_in.reset_cmd | cmd_in.prog_start | cmd_in.chip_start
                 | cmd_in.sector_start | cmd_in.suspend | cmd_in.resume;
    wire any_take = take_reset | take_prog | take_chip | take_sect
                  | take_susp | take_resume;
    // cell would need 0 to 1
    wire bad_prog = |(cmd_in.data & ~array_data_in);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_READ: begin
                if (take_prog) begin
                    state_d = ST_PROG;
                end else if (take_chip) begin
                    state_d = ST_ERASE;
                end else if (take_sect) begin
                    state_d = ST_EWAIT;
                end
            end
            ST_PROG: begin
                if (done) begin
                    state_d = ST_READ;
                end
            end
            ST_EWAIT: begin
                if (cmd_in.window_end) begin
                    state_d = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (done) begin
                    state_d = ST_READ;
                end else if (take_susp) begin
                    state_d = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (take_resume) begin
                    state_d = ST_ERASE;
                end
            end
            default: begin
                state_d = ST_READ;
            end
        endcase
        if (take_reset) begin
            state_d = ST_READ;
        end
    end

    // ----------------------------------------
    // Sector set under erasure
    // ----------------------------------------
    always_comb begin
        sect_d = sect_q;
        if (take_chip) begin
            sect_d = '1;
        end else if (take_sect) begin
            sect_d = (is_read ? '0 : sect_q) | (8'h01 << sector_of(cmd_in.addr));
        end else if (state_d == ST_READ) begin
            sect_d = '0;
        end
    end

    // ----------------------------------------
    // Timeout counter
    // ----------------------------------------
    // time limit on running algorithm
    // Suspension freezes the count, since erase time stands still
    always_comb begin
        tmo_cnt_d = tmo_cnt_q;
        tmo_d = tmo_q;
        if (state_d == ST_READ || is_read || is_ewait) begin
            tmo_cnt_d = '0;
            tmo_d = 1'b0;
        end else if (running && !tmo_q) begin
            tmo_cnt_d = tmo_cnt_q + 32'h00000001;
            if (tmo_cnt_q >= 32'(TIMEOUT_CYCLES - 1)) begin
                tmo_d = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    // only the commanding bank
    wire bank_hit = (bus_in.addr[`FLS_BANK_BIT] == bank_q);
    wire in_sect = sect_q[sector_of(bus_in.addr)];
    wire busy_sub = (running | is_ewait) & bank_hit;
    wire susp_sub = is_susp & in_sect & bank_hit;
    wire busy_read = bus_in.rd & busy_sub;
    logic [7:0] busy_status;

    always_comb begin
        busy_status = 8'h00;
        busy_status[`FLS_POLL_BIT] = is_prog & ~last_bit7_q;
        busy_status[`FLS_TOGGLE_BIT] = toggle_q;
        busy_status[`FLS_TIMEOUT_BIT] = tmo_q;
        // 0 in the window, 1 once erasing
        busy_status[`FLS_WINDOW_BIT] = is_erase;
    end

    assign rd_data_d = busy_sub ? busy_status :
                       susp_sub ? `FLS_SUSP_STATUS : array_data_in;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_q <= ST_READ;
            sect_q <= '0;
            tmo_q <= 1'b0;
            tmo_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            sect_q <= sect_d;
            tmo_q <= tmo_d;
            tmo_cnt_q <= tmo_cnt_d;
        end
    end

    // Captured at command start for the whole algorithm
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            bank_q <= 1'b0;
            last_bit7_q <= 1'b0;
            lock_q <= 1'b0;
            chip_q <= 1'b0;
        end else if (take_prog | take_chip | (take_sect & is_read)) begin
            bank_q <= cmd_in.addr[`FLS_BANK_BIT];
            last_bit7_q <= cmd_in.data[`FLS_POLL_BIT];
            lock_q <= take_prog & bad_prog;
            chip_q <= take_chip;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            toggle_q <= 1'b0;
        end else if (is_read) begin
            toggle_q <= 1'b0;
        end else if (busy_read) begin
            toggle_q <= ~toggle_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rd_data_q <= 8'h00;
        end else if (bus_in.rd) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_out = rd_data_q;
    assign busy_out = ~is_read;
    assign timeout_out = tmo_q;
    // Ignored commands are flagged, never queued
    assign cmd_ignored_out = any_cmd & ~any_take;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_busy_rd;
        bus_in.rd && busy_sub;
    endsequence

    sequence s_two_busy_rd;
        s_busy_rd ##1 s_busy_rd;
    endsequence

    a_poll_prog_inv: assert property (
        bus_in.rd && is_prog && bank_hit |=> rd_data_out[7] == !$past(last_bit7_q))
        else $error("polling flag not inverted while programming");

    a_idle_array_data: assert property (
        bus_in.rd && is_read |=> rd_data_out == $past(array_data_in))
        else $error("idle read not array data");

    a_poll_erase_zero: assert property (
        bus_in.rd && is_erase && bank_hit |=> !rd_data_out[7] && rd_data_out[3])
        else $error("erase status byte wrong");

    a_susp_sector: assert property (
        bus_in.rd && susp_sub |=> rd_data_out == `FLS_SUSP_STATUS)
        else $error("suspended sector status wrong");

    a_toggle_alt: assert property (
        s_two_busy_rd |=> rd_data_out[6] != $past(rd_data_out[6]))
        else $error("toggle flag did not alternate");

    a_timeout_set: assert property (
        running && !tmo_q && tmo_cnt_q == 32'(TIMEOUT_CYCLES - 1)
        && !take_reset && !done |=> tmo_q)
        else $error("timeout flag late");

    a_timeout_read: assert property (
        s_busy_rd |=> rd_data_out[5] == $past(tmo_q))
        else $error("timeout flag not on read");

    a_lock_holds: assert property (
        is_prog && lock_q && !take_reset |=> is_prog)
        else $error("locked program terminated");

    a_window_wait: assert property (
        bus_in.rd && is_ewait && bank_hit |=> rd_data_out[3] == 1'b0)
        else $error("window flag set during wait");

    a_erase_locked: assert property (
        is_erase && !cmd_in.suspend && !cmd_in.algo_done && !tmo_q |=> is_erase)
        else $error("erase left on a locked command");

    a_other_bank: assert property (
        bus_in.rd && !bank_hit |=> rd_data_out == $past(array_data_in))
        else $error("status leaked to other bank");

    a_spare_zero: assert property (
        s_busy_rd |=> (rd_data_out & `FLS_SPARE_MASK) == 8'h00)
        else $error("spare status bits not zero");

endmodule

// [core/flash_status_consts.svh]
// Constants for the flash status flag read-back block
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

// ----------------------------------------
// Status byte layout
// ----------------------------------------
`define FLS_POLL_BIT 3'd7
`define FLS_TOGGLE_BIT 3'd6
`define FLS_TIMEOUT_BIT 3'd5
`define FLS_WINDOW_BIT 3'd3
`define FLS_SPARE_MASK 8'h17
`define FLS_SUSP_STATUS 8'h48

// ----------------------------------------
// Address decode
// ----------------------------------------
`define FLS_BANK_BIT 15
`define FLS_SECT_MSB 15
`define FLS_SECT_LSB 13
`define FLS_NUM_SECT 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define FLS_CLK_PERIOD_NS 8
`define FLS_TIMEOUT_US 5000
`define FLS_TIMEOUT_CYCLES ((`FLS_TIMEOUT_US * 1000) / `FLS_CLK_PERIOD_NS)

`endif

// [core/flash_status_pkg.sv]
// Types for the flash status flag read-back block
package flash_status_pkg;

    // ----------------------------------------
    // CPU read request
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
    } cpu_rd_t;

    // ----------------------------------------
    // Decoded commands and engine events
    // ----------------------------------------
    typedef struct packed {
        logic prog_start;
        logic chip_start;
        logic sector_start;
        logic suspend;
        logic resume;
        logic reset_cmd;
        logic algo_done;
        logic window_end;
        logic [15:0] addr;
        logic [7:0] data;
    } seq_cmd_t;

    typedef enum logic [2:0] {
        ST_READ,
        ST_PROG,
        ST_EWAIT,
        ST_ERASE,
        ST_SUSP
    } seq_state_t;

endpackage

// [dv/flash_array_model.sv]
// Flash array stand-in feeding array bytes to the status block
`timescale 1ns/100ps
module flash_array_model (
    input wire flash_status_pkg::cpu_rd_t bus_in,
    input wire flash_status_pkg::seq_cmd_t cmd_in,
    output logic [7:0] array_data_out
);
    import flash_status_pkg::*;
    // ----------------------------------------
    // Array contents
    // ----------------------------------------
    logic [15:0] sel_addr;
    // Program start looks at the target cell, otherwise the read address
    assign sel_addr = cmd_in.prog_start ? cmd_in.addr : bus_in.addr;
    // Sector 2 all zero so programming ones there locks the engine
    assign array_data_out = (sel_addr[15:13] == 3'h2) ? 8'h00 :
        sel_addr[13] ? 8'hFF : (sel_addr[7:0] ^ sel_addr[15:8]);
endmodule

// [dv/flash_status_flag_readback_bench.sv]
// Self-checking bench for the flash status read-back block
`timescale 1ns/100ps
module flash_status_flag_readback_bench;
    import flash_status_pkg::*;
    // ----------------------------------------
    // Clock, reset and model state
    // ----------------------------------------
    // Short timeout keeps the lock scenarios brief
    localparam int TO = 40;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    cpu_rd_t bus_in = '0;
    seq_cmd_t cmd_in = '0;
    logic [7:0] array_data_in;
    logic [7:0] rd_data_out;
    logic busy_out;
    logic timeout_out;
    logic cmd_ignored_out;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'hF971466E;
    int st = 0;
    int bk = 0;
    int pd7 = 0;
    int to = 0;
    int tg = 0;
    logic [7:0] sect_m = 8'h00;
    logic [15:0] a;
    logic [7:0] d;

    always #4 clk_in = ~clk_in;

    flash_status_flag_readback #(.TIMEOUT_CYCLES(TO)) flash_status_flag_readback_i (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in),
        .array_data_in(array_data_in), .cmd_in(cmd_in), .rd_data_out(rd_data_out),
        .busy_out(busy_out), .timeout_out(timeout_out), .cmd_ignored_out(cmd_ignored_out));

    flash_array_model flash_array_model_i (
        .bus_in(bus_in), .cmd_in(cmd_in), .array_data_out(array_data_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic conclude();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g,
                       input logic [7:0] m);
        checked++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e & m, g & m);
        end
    endtask

    function automatic logic [7:0] arr(input logic [15:0] x);
        if (x[15:13] == 3'h2) return 8'h00;
        if (x[13]) return 8'hFF;
        return x[7:0] ^ x[15:8];
    endfunction

    function automatic logic [7:0] expect_byte(input logic [15:0] x);
        if (st == 0 || x[15] != bk[0]) return arr(x);
        case (st)
            1: return {~pd7[0], tg[0], to[0], 5'h00};
            2: return {1'b0, tg[0], 6'h00};
            3: return {1'b0, tg[0], to[0], 5'h08};
            default: return sect_m[x[15:13]] ? 8'h48 : arr(x);
        endcase
    endfunction

    task automatic flags();
        chk("busy timeout", {6'h00, st != 0, to[0]}, {6'h00, busy_out, timeout_out}, 8'hFF);
    endtask

    task automatic rd(input logic [15:0] x, input string what, input int n = 1);
        logic [7:0] m;
        @(posedge clk_in);
        bus_in <= '{addr: x, rd: 1'b1};
        // Strobe stays high for n back-to-back reads of one address
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (i == n - 1) bus_in.rd <= 1'b0;
            // Toggle phase unknown after a suspend, so bit 6 is skipped once
            m = (tg < 0 && st != 4) ? 8'hBF : 8'hFF;
            #1;
            chk(what, expect_byte(x), rd_data_out, m);
            if (st inside {[1:3]} && x[15] == bk[0]) tg = (tg < 0) ? 1 - rd_data_out[6] : 1 - tg;
        end
    endtask

    task automatic cmd(input logic [7:0] f, input logic [15:0] x, input logic [7:0] dd,
                       input logic ign);
        @(posedge clk_in);
        cmd_in <= {f, x, dd};
        #1;
        if (ign !== 1'bx) chk("cmd_ignored_out", {7'h00, ign}, {7'h00, cmd_ignored_out}, 8'hFF);
        @(posedge clk_in);
        cmd_in <= '0;
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk("reset", 8'h00, rd_data_out | {6'h00, busy_out, timeout_out}, 8'hFF);
        for (int i = 0; i < 6; i++) rd(16'($random(seed)), "idle read"); // Plain data
        a = {3'h1, 13'($random(seed))};
        d = 8'($random(seed));
        cmd(8'h80, a, d, 1'b0);
        st = 1; bk = a[15]; pd7 = d[7]; tg = 0; flags(); // Programming
        rd(a, "prog status", 3); // Program byte
        rd(a ^ 16'h8000, "other bank"); // Foreign bank
        cmd(8'h04, a, 8'h00, 1'b1); // Reset refused
        cmd(8'h02, a, 8'h00, 1'bx);
        st = 0; tg = 0; flags();
        rd(a, "prog done"); // Data after done
        a = {3'h2, 13'($random(seed))};
        cmd(8'h80, a, 8'hFF, 1'b0);
        st = 1; bk = a[15]; pd7 = 1; flags(); // Within time
        rd(a, "locked status"); // Locked
        cmd(8'h02, a, 8'h00, 1'bx);
        repeat (TO + 5) @(posedge clk_in);
        to = 1; flags(); // Lock timeout
        repeat (2) rd(a, "locked timed out"); // Still toggling
        cmd(8'h04, a, 8'h00, 1'b0); // CPU recovery
        st = 0; to = 0; tg = 0; flags();
        a = {3'h5, 13'($random(seed))};
        cmd(8'h20, a, 8'h30, 1'b0);
        st = 2; bk = 1; sect_m = 8'h20; flags();
        rd(a, "window"); // Window open
        cmd(8'h20, 16'hE000, 8'h30, 1'b0); // Second sector
        sect_m = 8'hA0;
        cmd(8'h01, a, 8'h00, 1'bx);
        st = 3;
        repeat (2) rd(16'hE123, "erasing"); // Erase byte
        cmd(8'h80, a, 8'h00, 1'b1); // Only suspend taken
        cmd(8'h10, a, 8'hB0, 1'b0);
        st = 4; tg = -1;
        rd(a, "suspended sector"); // Suspended
        rd(16'h8ABC, "suspended other"); // Untouched sector
        cmd(8'h08, a, 8'h30, 1'b0);
        st = 3;
        rd(a, "resumed", 3); // Resumed
        cmd(8'h02, a, 8'h00, 1'bx);
        st = 0; tg = 0; flags();
        rd(a, "erase done"); // Polling one
        a = 16'($random(seed)) & 16'h7FFF;
        cmd(8'h40, a, 8'h10, 1'b0);
        st = 3; bk = 0; flags();
        cmd(8'h10, a, 8'hB0, 1'b1); // No suspend of chip erase
        repeat (TO + 5) @(posedge clk_in);
        to = 1; flags(); // Erase timeout
        rd(a, "chip timed out", 2); // Still toggling
        cmd(8'h04, a, 8'h00, 1'b0); // CPU recovery
        st = 0; to = 0; flags();
        conclude();
    end
endmodule
